// ### adsq_pkg.sv
// Package: register map, field layout and shared types of the sequencer
package adsq_pkg;
    // ==========================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_RESULT0 = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_CTRL2 = 8'h24;
    localparam int NUM_RESULTS = 8;
    // ==========================================
    // Status register fields
    localparam int CS_FLAG = 7;
    localparam int CS_IE = 6;
    localparam int CS_START = 5;
    localparam int CS_GRP = 3;
    localparam logic [7:0] CS_RESET = 8'h00;
    // ==========================================
    // Second control register fields
    localparam int C2_PWR = 6;
    localparam int C2_TRG_LO = 4;
    localparam int C2_SCAN = 3;
    localparam int C2_DUAL_SAMPLE_ENABLE = 2;
    localparam int C2_BUF_LO = 0;
    localparam logic [7:0] C2_RESET = 8'h00;
    localparam logic [7:0] C2_WMASK = 8'h7f;
    localparam logic [15:0] RES_RESET = 16'h0000;
    // ==========================================
    // Codes
    localparam logic [1:0] TRG_SW = 2'h0;
    localparam logic [1:0] TRG_TIMER = 2'h1;
    localparam logic [1:0] TRG_PIN = 2'h3;
    localparam logic [1:0] BUF_AB = 2'h1;
    localparam logic [1:0] BUF_AC_BD = 2'h2;
    localparam logic [1:0] BUF_ABCD = 2'h3;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    // ==========================================
    // Types
    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_HOLD} adsq_state_t;
    typedef struct packed {
        logic [2:0] chan;
        logic dual;
        logic fast;
    } adsq_conv_req_t;
    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic byte_sz;
    } adsq_bus_ph_t;
endpackage

// ### adsq_top.sv
// Converter sequencer control with AHB-Lite register slave
module adsq_top (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_standby,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    output adsq_pkg::adsq_conv_req_t o_conv_req,
    output logic o_conv_go,
    input wire logic i_conv_done,
    input wire logic [9:0] i_conv_data,
    input wire logic i_timer_trig,
    input wire logic i_ext_trig_pin,
    output logic o_end_irq
);
    import adsq_pkg::*;

    // ==========================================
    // State
    logic [7:0] cs_reg, cs_next, c2_reg, c2_next;
    logic [15:0] res_reg [NUM_RESULTS];
    logic [15:0] res_next [NUM_RESULTS];
    adsq_state_t st_reg, st_next;
    logic [2:0] ch_reg, ch_next;
    logic seen_reg, seen_next;
    adsq_bus_ph_t ph_reg, ph_next;
    logic pend_reg, pend_next, rdy_reg, rdy_next;
    logic [31:0] rd_reg, rd_next;
    logic [2:0] pin_reg, pin_next;
    logic pin_lvl_reg, pin_lvl_next;
    adsq_conv_req_t req_reg, req_next;
    logic go_reg, go_next, irq_reg, irq_next;
    logic wr_cs, wr_c2, rd_cs, hw_trig, round_end, accept;
    logic [2:0] first_ch;
    logic [15:0] sel_res;
    logic [15:0] new_res;

    // ==========================================
    // Bus decode
    always_comb begin
        accept = i_hsel && i_htrans[1] && i_hready;
        wr_cs = pend_reg && ph_reg.write && ph_reg.addr == OFS_STATUS;
        wr_c2 = pend_reg && ph_reg.write && ph_reg.addr == OFS_CTRL2;
        rd_cs = pend_reg && !ph_reg.write && ph_reg.addr == OFS_STATUS;
        sel_res = res_reg[ph_reg.addr[4:2]];
        new_res = {6'h00, i_conv_data};
        first_ch = cs_reg[CS_GRP] ? 3'h0 : cs_reg[2:0];
        round_end = st_reg == ST_WAIT && cs_reg[CS_START] && i_conv_done
            && ch_reg == cs_reg[2:0];
        case (c2_reg[C2_TRG_LO +: 2])
            TRG_TIMER: hw_trig = i_timer_trig;
            TRG_PIN: hw_trig = pin_lvl_next && !pin_lvl_reg;
            default: hw_trig = 1'b0;
        endcase
    end

    // ==========================================
    // Next-state logic
    always_comb begin
        cs_next = cs_reg;
        c2_next = c2_reg;
        res_next = res_reg;
        st_next = st_reg;
        ch_next = ch_reg;
        seen_next = seen_reg;
        ph_next = ph_reg;
        pend_next = 1'b0;
        rdy_next = rdy_reg;
        rd_next = rd_reg;
        go_next = 1'b0;
        // Pin filter: level counts once the later stages agree
        pin_next = {pin_reg[1:0], i_ext_trig_pin};
        pin_lvl_next = (pin_reg[1] == pin_reg[2]) ? pin_reg[2] : pin_lvl_reg;
        // Bus: one wait state, answer from registers
        if (accept) begin
            ph_next.addr = i_haddr[7:0];
            ph_next.write = i_hwrite;
            ph_next.byte_sz = i_hsize == HSIZE_BYTE;
            pend_next = 1'b1;
            rdy_next = 1'b0;
        end
        if (pend_reg) begin
            rdy_next = 1'b1;
            rd_next = 32'h0000_0000;
            if (!ph_reg.write) begin
                if (ph_reg.addr < OFS_STATUS) begin
                    if (ph_reg.byte_sz) begin
                        rd_next = {4{sel_res[9:2]}};
                    end else begin
                        rd_next = {16'h0000, sel_res};
                    end
                end else if (ph_reg.addr == OFS_STATUS) begin
                    rd_next = {24'h000000, cs_reg};
                end else if (ph_reg.addr == OFS_CTRL2) begin
                    rd_next = {24'h000000, c2_reg & C2_WMASK};
                end
            end
        end
        if (rd_cs && cs_reg[CS_FLAG]) begin
            seen_next = 1'b1;
        end
        if (wr_c2) begin
            c2_next = i_hwdata[7:0] & C2_WMASK;
        end
        if (wr_cs) begin
            cs_next[6:0] = i_hwdata[6:0];
            if (!i_hwdata[CS_FLAG] && seen_reg) begin
                cs_next[CS_FLAG] = 1'b0;
                seen_next = 1'b0;
            end
        end
        if (hw_trig) begin
            cs_next[CS_START] = 1'b1;
        end
        // Sequencer
        case (st_reg)
            ST_IDLE: begin
                if (cs_reg[CS_START]) begin
                    ch_next = first_ch;
                    st_next = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                go_next = cs_reg[CS_START];
                st_next = cs_reg[CS_START] ? ST_WAIT : ST_IDLE;
            end
            ST_WAIT: begin
                if (!cs_reg[CS_START]) begin
                    st_next = ST_IDLE;
                end else if (i_conv_done) begin
                    case (c2_reg[C2_BUF_LO +: 2])
                        BUF_AB: begin
                            if (ch_reg == 3'h0) begin
                                res_next[1] = res_reg[0];
                            end
                        end
                        BUF_AC_BD: begin
                            if (ch_reg == 3'h0) begin
                                res_next[2] = res_reg[0];
                            end else if (ch_reg == 3'h1) begin
                                res_next[3] = res_reg[1];
                            end
                        end
                        BUF_ABCD: begin
                            if (ch_reg == 3'h0) begin
                                res_next[3] = res_reg[2];
                                res_next[2] = res_reg[1];
                                res_next[1] = res_reg[0];
                            end
                        end
                        default: begin
                        end
                    endcase
                    res_next[ch_reg] = new_res;
                    if (round_end) begin
                        cs_next[CS_FLAG] = 1'b1;
                        ch_next = first_ch;
                        if (!c2_reg[C2_SCAN]) begin
                            if (!(wr_cs && i_hwdata[CS_START])) begin
                                cs_next[CS_START] = 1'b0;
                            end
                            st_next = ST_IDLE;
                        end else begin
                            st_next = cs_reg[CS_IE] ? ST_HOLD : ST_ISSUE;
                        end
                    end else begin
                        ch_next = ch_reg + 3'h1;
                        st_next = ST_ISSUE;
                    end
                end
            end
            ST_HOLD: begin
                if (!cs_reg[CS_START]) begin
                    st_next = ST_IDLE;
                end else if (!cs_reg[CS_FLAG]) begin
                    st_next = ST_ISSUE;
                end
            end
            default: st_next = ST_IDLE;
        endcase
        req_next.chan = ch_next;
        req_next.dual = c2_reg[C2_DUAL_SAMPLE_ENABLE];
        req_next.fast = c2_reg[C2_PWR];
        if (i_standby) begin
            cs_next = CS_RESET;
            c2_next = C2_RESET;
            seen_next = 1'b0;
            st_next = ST_IDLE;
            for (int i = 0; i < NUM_RESULTS; i++) begin
                res_next[i] = RES_RESET;
            end
        end
        irq_next = cs_next[CS_FLAG] && cs_next[CS_IE];
    end

    // ==========================================
    // Registers
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            cs_reg <= CS_RESET;
            c2_reg <= C2_RESET;
            for (int i = 0; i < NUM_RESULTS; i++) begin
                res_reg[i] <= RES_RESET;
            end
            st_reg <= ST_IDLE;
            ch_reg <= 3'h0;
            seen_reg <= 1'b0;
            ph_reg <= '0;
            pend_reg <= 1'b0;
            rdy_reg <= 1'b1;
            rd_reg <= 32'h0000_0000;
            pin_reg <= 3'h0;
            pin_lvl_reg <= 1'b0;
            req_reg <= '0;
            go_reg <= 1'b0;
            irq_reg <= 1'b0;
            o_hresp <= 1'b0;
        end else begin
            cs_reg <= cs_next;
            c2_reg <= c2_next;
            res_reg <= res_next;
            st_reg <= st_next;
            ch_reg <= ch_next;
            seen_reg <= seen_next;
            ph_reg <= ph_next;
            pend_reg <= pend_next;
            rdy_reg <= rdy_next;
            rd_reg <= rd_next;
            pin_reg <= pin_next;
            pin_lvl_reg <= pin_lvl_next;
            req_reg <= req_next;
            go_reg <= go_next;
            irq_reg <= irq_next;
            o_hresp <= 1'b0;
        end
    end

    assign o_hreadyout = rdy_reg;
    assign o_hrdata = rd_reg;
    assign o_conv_req = req_reg;
    assign o_conv_go = go_reg;
    assign o_end_irq = irq_reg;

    // ==========================================
    // Checks
    standby_clear_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        i_standby |=> c2_reg == C2_RESET)
        else $error("control two not cleared by standby");
    top_bit_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        pend_reg && !ph_reg.write && ph_reg.addr == OFS_CTRL2
        |=> o_hrdata[7] == 1'b0)
        else $error("reserved control bit read as one");
    byte_read_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        pend_reg && !ph_reg.write && ph_reg.byte_sz && ph_reg.addr < OFS_STATUS
        |=> o_hrdata[7:0] == $past(sel_res[9:2]) && o_hreadyout)
        else $error("byte read returned wrong bits");
    single_stop_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        round_end && !c2_reg[C2_SCAN] && !wr_cs && !hw_trig && !i_standby
        |=> !cs_reg[CS_START] && st_reg == ST_IDLE)
        else $error("single mode did not stop");
    scan_keep_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        round_end && c2_reg[C2_SCAN] && !wr_cs && !i_standby
        |=> cs_reg[CS_START] && cs_reg[CS_FLAG])
        else $error("scan mode dropped start");
    abort_halt_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        st_reg == ST_WAIT && !cs_reg[CS_START] |=> st_reg == ST_IDLE ##1 !o_conv_go)
        else $error("abort did not halt");
    chain_abcd_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        round_end && c2_reg[1:0] == BUF_ABCD && ch_reg == 3'h0 && !i_standby
        |=> res_reg[1] == $past(res_reg[0]) && res_reg[0][9:0] == $past(i_conv_data))
        else $error("chain did not shift");
    rsvd_trig_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        c2_reg[C2_TRG_LO +: 2] == 2'h2 && st_reg == ST_IDLE && !cs_reg[CS_START]
        && !wr_cs |=> !cs_reg[CS_START])
        else $error("reserved trigger started conversion");
    end_irq_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        round_end && cs_reg[CS_IE] && !wr_cs && !i_standby |=> ##1 o_end_irq)
        else $error("end request missing");
    bus_wait_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        accept |=> !o_hreadyout ##1 o_hreadyout)
        else $error("bus wait state wrong");
endmodule // adsq_top

// ### adsq_analog_model.sv
// Behavioural model of the analog conversion side
module adsq_analog_model
    import adsq_pkg::*;
#(
    parameter int DLY = 8
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire adsq_pkg::adsq_conv_req_t i_req,
    input wire logic i_go,
    output logic o_done,
    output logic [9:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    logic [6:0] seq = 7'h00;
    logic [9:0] val = 10'h000;
    initial o_done = 1'b0;
    initial o_data = 10'h000;
    // ==========================================
    // One conversion at a time, ten-bit result
    always @(posedge i_core_clk) begin
        o_done <= (cnt == 1) && !i_srst;
        o_data <= (cnt == 1) ? val : ~val;
        if (i_srst) begin
            cnt <= 0;
            seq <= 7'h00;
        end else if (i_go) begin
            cnt <= DLY;
            val <= {i_req.chan, seq};
            seq <= seq + 7'h01;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule // adsq_analog_model

// ### adc_sequencer_control_test.sv
// Self-checking bench for the converter sequencer
module adc_sequencer_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import adsq_pkg::*;
    // ==========================================
    // Signals
    logic clk = 0, srst = 1, stby = 0, hsel = 0, hw = 0, tmr = 0, pin = 0;
    logic [31:0] ha = 0, hwd = 0, hrd;
    logic [1:0] htr = 0;
    logic [2:0] hsz = 0;
    logic hrdy, hresp, go, done, irq;
    logic [9:0] cd;
    adsq_conv_req_t req;
    logic [11:0] q[$];
    logic [6:0] ngo = 0;
    int mismatches = 0;
    int tests_run = 0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (go === 1'b1) begin
            q.push_back({req.dual, req.fast, req.chan, ngo});
            ngo <= ngo + 7'h01;
        end
    end
    adsq_top adsq_top_i (.i_core_clk(clk), .i_srst(srst), .i_standby(stby),
        .i_hsel(hsel), .i_haddr(ha), .i_htrans(htr), .i_hwrite(hw),
        .i_hsize(hsz), .i_hwdata(hwd), .i_hready(hrdy), .o_hreadyout(hrdy),
        .o_hresp(hresp), .o_hrdata(hrd), .o_conv_req(req), .o_conv_go(go),
        .i_conv_done(done), .i_conv_data(cd), .i_timer_trig(tmr),
        .i_ext_trig_pin(pin), .o_end_irq(irq));
    adsq_analog_model adsq_analog_model_i (.i_core_clk(clk), .i_srst(srst),
        .i_req(req), .i_go(go), .o_done(done), .o_data(cd));
    // ==========================================
    // Shared tasks
    task automatic complete_run;
        $display("Counts: %0d run, %0d mismatched", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e, input string m);
        tests_run++;
        if (g !== e) begin
            $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
            mismatches++;
        end
    endtask
    task automatic tmo(input string m);
        $display("[ERR] %0t timeout %s", $time, m);
        mismatches++;
        complete_run();
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d, input logic b, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        hsel <= 1'b1;
        htr <= 2'h2;
        ha <= {24'h0, a};
        hw <= w;
        hsz <= b ? HSIZE_BYTE : 3'h2;
        do begin @(posedge clk); n++; end while (hrdy !== 1'b1 && n < 20);
        if (n >= 20) tmo("bus address");
        hsel <= 1'b0;
        htr <= 2'h0;
        hwd <= d;
        do begin @(posedge clk); n++; end while (hrdy !== 1'b1 && n < 40);
        r = hrd;
        if (n >= 40) tmo("bus");
        chk({31'h0, hresp}, 32'h0, "response");
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, {24'h0, d}, 1'b0, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h0, 1'b0, r);
    endtask
    task automatic wait_idle(output logic [31:0] s);
        int n;
        n = 0;
        do begin rd(OFS_STATUS, s); n++; end while (s[CS_START] && n < 100);
        if (n >= 100) tmo("start bit");
    endtask
    task automatic chk_res(input logic [11:0] e);
        logic [31:0] r;
        rd({3'h0, e[9:7], 2'h0}, r);
        chk(r, {22'h0, e[9:0]}, "word read");
        bus(1'b0, {3'h0, e[9:7], 2'h0}, 32'h0, 1'b1, r);
        chk(r, {4{e[9:2]}}, "byte read");
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset;
        logic [31:0] r;
        rd(OFS_CTRL2, r);
        chk(r, {24'h0, C2_RESET}, "ctrl2 reset");
        rd(OFS_STATUS, r);
        chk(r, {24'h0, CS_RESET}, "status reset");
        rd(OFS_RESULT0, r);
        chk(r, {16'h0, RES_RESET}, "result reset");
        rd(8'h40, r);
        chk(r, 32'h0, "unmapped");
        $display("test reset done");
    endtask
    task automatic t_ctrl;
        logic [31:0] r;
        logic [7:0] v;
        wr(OFS_CTRL2, 8'hff);
        rd(OFS_CTRL2, r);
        chk(r, 32'h7f, "top bit");
        for (int i = 0; i < 4; i++) begin
            v = {1'b0, i[0], i[1:0], i[1], i[0], i[1:0]};
            wr(OFS_CTRL2, v);
            rd(OFS_CTRL2, r);
            chk(r, {24'h0, v}, "ctrl2 field");
        end
        $display("test ctrl2 done");
    endtask
    task automatic t_conv(input logic [7:0] c2, cs, input int nch);
        logic [31:0] s;
        logic [2:0] ch;
        wr(OFS_CTRL2, c2);
        q.delete();
        wr(OFS_STATUS, cs | 8'h20);
        rd(OFS_STATUS, s);
        chk(s[CS_START], 1'b1, "start held");
        wait_idle(s);
        chk(s[CS_FLAG], 1'b1, "end flag");
        chk(q.size(), nch, "count");
        for (int i = 0; i < q.size(); i++) begin
            ch = cs[CS_GRP] ? 3'(i) : cs[2:0];
            chk(q[i][9:7], ch, "channel");
            chk(q[i][11:10], {c2[C2_DUAL_SAMPLE_ENABLE], c2[C2_PWR]}, "mode");
            chk_res(q[i]);
        end
        wr(OFS_STATUS, 8'h00);
        rd(OFS_STATUS, s);
        chk(s, 32'h0, "flag clear");
        $display("test conversion done");
    endtask
    task automatic t_buffer;
        logic [31:0] s;
        wr(OFS_CTRL2, 8'h01);
        q.delete();
        wr(OFS_STATUS, 8'h20);
        wait_idle(s);
        wr(OFS_STATUS, 8'h00);
        wr(OFS_STATUS, 8'h60);
        wait_idle(s);
        chk(q.size(), 2, "count");
        rd(OFS_RESULT0 + 8'h04, s);
        chk(s, {22'h0, q[0][9:0]}, "buffer b");
        chk_res(q[1]);
        chk(irq, 1'b1, "irq set");
        wr(OFS_STATUS, 8'h40);
        cyc(2);
        chk(irq, 1'b0, "irq clear");
        wr(OFS_CTRL2, 8'h03);
        wr(OFS_STATUS, 8'h20);
        wait_idle(s);
        wr(OFS_STATUS, 8'h00);
        chk(q.size(), 3, "count abcd");
        rd(OFS_RESULT0 + 8'h08, s);
        chk(s, {22'h0, q[0][9:0]}, "buffer c");
        rd(OFS_RESULT0 + 8'h04, s);
        chk(s, {22'h0, q[1][9:0]}, "buffer b4");
        chk_res(q[2]);
        wr(OFS_CTRL2, 8'h02);
        wr(OFS_STATUS, 8'h29);
        wait_idle(s);
        wr(OFS_STATUS, 8'h00);
        chk(q.size(), 5, "count pairs");
        rd(OFS_RESULT0 + 8'h08, s);
        chk(s, {22'h0, q[2][9:0]}, "buffer c pair");
        rd(OFS_RESULT0 + 8'h0c, s);
        chk(s, {22'h0, q[1][9:0]}, "buffer d pair");
        chk_res(q[3]);
        chk_res(q[4]);
        $display("test buffer done");
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic t_trig;
        logic [31:0] s;
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CTRL2, {2'h0, i[1:0], 4'h0});
            q.delete();
            tmr <= 1'b1;
            pin <= 1'b1;
            cyc(1);
            tmr <= 1'b0;
            cyc(6);
            pin <= 1'b0;
            cyc(4);
            wait_idle(s);
            chk(q.size(), i[0], "trigger");
            wr(OFS_STATUS, 8'h00);
        end
        $display("test trigger done");
    endtask
    task automatic t_scan;
        logic [31:0] s;
        int n;
        wr(OFS_CTRL2, 8'h08);
        q.delete();
        wr(OFS_STATUS, 8'h21);
        n = 0;
        while (q.size() < 3 && n < 300) begin cyc(1); n++; end
        if (n >= 300) tmo("scan");
        wr(OFS_STATUS, 8'h00);
        cyc(30);
        n = q.size();
        cyc(40);
        chk(q.size(), n, "halted");
        rd(OFS_STATUS, s);
        chk(s[CS_START], 1'b0, "start off");
        foreach (q[i]) chk(q[i][9:7], 3'h1, "scan chan");
        wr(OFS_STATUS, 8'h00);
        $display("test scan done");
    endtask
    task automatic t_standby;
        logic [31:0] r;
        wr(OFS_CTRL2, 8'h7f);
        stby <= 1'b1;
        cyc(1);
        stby <= 1'b0;
        rd(OFS_CTRL2, r);
        chk(r, 32'h0, "standby");
        rd(OFS_RESULT0, r);
        chk(r, {16'h0, RES_RESET}, "standby result");
        $display("test standby done");
    endtask
    // ==========================================
    // Main sequence
    initial begin
        cyc(10);
        srst <= 1'b0;
        t_reset();
        t_ctrl();
        t_conv(8'h00, 8'h05, 1);
        t_conv(8'h44, 8'h0a, 3);
        t_conv(8'h40, 8'h0f, 8);
        t_buffer();
        t_trig();
        t_scan();
        t_standby();
        complete_run();
    end
endmodule // adc_sequencer_control_test
